// file: rtl/smr_top.sv
// serial message recognizer: framed serial port, delimiter matcher, message stores
`include "smr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module smr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  input wire logic rxd,
  output logic txd_q,
  output logic [2:0] mode_q,
  output logic live_valid_q
);
  // ****************************************
  // configuration
  // ****************************************
  smr_pkg::smr_cfg_type cfg_q;
  logic [31:0] delim_q;
  logic [2:0] dlen_q;
  logic [15:0] idle_ms_q;
  logic [15:0] actv_ms_q;
  logic [5:0] idx_q;
  logic cmd_clear;
  logic cmd_reload;
  logic tx_go;
  assign cmd_clear = wr && addr == `SMR_A_CMD && wdata[0];
  assign cmd_reload = wr && addr == `SMR_A_CMD && wdata[1];
  assign tx_go = wr && addr == `SMR_A_TX;

  // one mode register drives the mode_q port; a write of zero leaves it unchanged
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      mode_q <= 3'h1;
    else if (wr && addr == `SMR_A_CFG && wdata[18:16] != 3'h0)
      mode_q <= wdata[18:16];

  // recognizer settings held once, so both ports see the same values
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cfg_q <= `SMR_CFG_RST;
      delim_q <= `SMR_DELIM_RST;
      dlen_q <= `SMR_DLEN_RST;
      idle_ms_q <= `SMR_IDLE_RST;
      actv_ms_q <= `SMR_ACTV_RST;
    end
    else if (cmd_reload)
    begin
      cfg_q <= {cfg_q[15:9], 1'h0, 1'h0, cfg_q[6:0]};
      delim_q <= `SMR_DELIM_RST;
      dlen_q <= `SMR_DLEN_RST;
      idle_ms_q <= `SMR_IDLE_RST;
      actv_ms_q <= `SMR_ACTV_RST;
    end
    else if (wr)
      case (addr)
        `SMR_A_CFG: cfg_q <= wdata[15:0];
        `SMR_A_DELIM: delim_q <= wdata;
        `SMR_A_DLEN: dlen_q <= (wdata[2:0] == 3'h0 || wdata[2:0] > 3'h4) ? 3'h1 : wdata[2:0];
        `SMR_A_IDLE: idle_ms_q <= wdata[15:0];
        `SMR_A_ACTV: actv_ms_q <= wdata[15:0];
        default: ;
      endcase

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      idx_q <= 6'h00;
    else if (wr && addr == `SMR_A_IDX)
      idx_q <= wdata[5:0];

  // ****************************************
  // bit timing
  // ****************************************
  function automatic logic [15:0] bit_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: bit_cycles = 16'(`SMR_CLK_HZ / 4800);
      3'h1: bit_cycles = 16'(`SMR_CLK_HZ / 7200);
      3'h2: bit_cycles = 16'(`SMR_CLK_HZ / 9600);
      3'h3: bit_cycles = 16'(`SMR_CLK_HZ / 14400);
      3'h4: bit_cycles = 16'(`SMR_CLK_HZ / 19200);
      3'h5: bit_cycles = 16'(`SMR_CLK_HZ / 38400);
      3'h6: bit_cycles = 16'(`SMR_CLK_HZ / 57600);
      default: bit_cycles = 16'(`SMR_CLK_HZ / 115200);
    endcase
  endfunction

  function automatic logic [16:0] stop_cycles(input logic [15:0] bt, input logic [1:0] st);
    case (st)
      2'h1: stop_cycles = {1'b0, bt} + {2'b0, bt[15:1]};
      2'h2: stop_cycles = {bt, 1'b0};
      default: stop_cycles = {1'b0, bt};
    endcase
  endfunction

  logic [15:0] bt;
  logic [3:0] nbits;
  assign bt = bit_cycles(cfg_q.baud);
  assign nbits = cfg_q.spare[0] ? 4'h9 : 4'h8;

  // ****************************************
  // receiver
  // ****************************************
  smr_pkg::smr_state_type rs_q;
  logic [16:0] rcnt_q;
  logic [3:0] rbit_q;
  logic [8:0] rsh_q;
  logic rpar_q;
  logic rx_stb_q;
  logic [7:0] rx_byte_q;
  logic rx_err_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rs_q <= smr_pkg::SMR_S_IDLE;
      rcnt_q <= 17'h00000;
      rbit_q <= 4'h0;
      rsh_q <= 9'h000;
      rpar_q <= 1'b0;
      rx_stb_q <= 1'b0;
      rx_byte_q <= 8'h00;
      rx_err_q <= 1'b0;
    end
    else
    begin
      rx_stb_q <= 1'b0;
      case (rs_q)
        smr_pkg::SMR_S_IDLE:
          if (!rxd)
          begin
            rs_q <= smr_pkg::SMR_S_START;
            rcnt_q <= {2'b0, bt[15:1]};
          end
        smr_pkg::SMR_S_START:
          if (rcnt_q != 17'h0)
            rcnt_q <= rcnt_q - 17'h1;
          else if (rxd)
            rs_q <= smr_pkg::SMR_S_IDLE;
          else
          begin
            rs_q <= smr_pkg::SMR_S_DATA;
            // the zero cycle belongs to the bit, so reload one less than a bit time
            rcnt_q <= {1'b0, bt} - 17'h1;
            rbit_q <= 4'h0;
            rpar_q <= cfg_q.parity == smr_pkg::SMR_PAR_ODD;
          end
        smr_pkg::SMR_S_DATA:
          if (rcnt_q != 17'h0)
            rcnt_q <= rcnt_q - 17'h1;
          else
          begin
            rsh_q <= {rxd, rsh_q[8:1]};
            rpar_q <= rpar_q ^ rxd;
            rbit_q <= rbit_q + 4'h1;
            rcnt_q <= {1'b0, bt} - 17'h1;
            if (rbit_q == nbits - 4'h1)
              rs_q <= cfg_q.parity == smr_pkg::SMR_PAR_NONE ? smr_pkg::SMR_S_STOP
                : smr_pkg::SMR_S_PAR;
          end
        smr_pkg::SMR_S_PAR:
          if (rcnt_q != 17'h0)
            rcnt_q <= rcnt_q - 17'h1;
          else
          begin
            rx_err_q <= rpar_q ^ rxd;
            rcnt_q <= {1'b0, bt} - 17'h1;
            rs_q <= smr_pkg::SMR_S_STOP;
          end
        smr_pkg::SMR_S_STOP:
          if (rcnt_q != 17'h0)
            rcnt_q <= rcnt_q - 17'h1;
          else
          begin
            // only one stop bit is sampled; the rest is idle line anyway
            rs_q <= smr_pkg::SMR_S_IDLE;
            rx_stb_q <= rxd;
            rx_byte_q <= nbits == 4'h9 ? rsh_q[7:0] : rsh_q[8:1];
          end
        default: rs_q <= smr_pkg::SMR_S_IDLE;
      endcase
    end

  // ****************************************
  // transmitter
  // ****************************************
  logic [11:0] tsh_q;
  logic [3:0] tleft_q;
  logic [16:0] tcnt_q;
  logic tbusy_q;
  logic tpar;
  logic pbit;
  assign tpar = (cfg_q.spare[0] ? ^wdata[8:0] : ^wdata[7:0])
    ^ (cfg_q.parity == smr_pkg::SMR_PAR_ODD);
  assign pbit = cfg_q.parity == smr_pkg::SMR_PAR_NONE ? 1'b1 : tpar;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      tsh_q <= 12'hFFF;
      tleft_q <= 4'h0;
      tcnt_q <= 17'h00000;
      tbusy_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else if (!tbusy_q)
    begin
      txd_q <= 1'b1;
      if (tx_go)
      begin
        tbusy_q <= 1'b1;
        txd_q <= 1'b0;
        tcnt_q <= {1'b0, bt} - 17'h1;
        // data, then parity if any, then the stop bit; ones fill the rest
        if (cfg_q.spare[0])
          tsh_q <= {2'b11, pbit, wdata[8:0]};
        else
          tsh_q <= {3'b111, pbit, wdata[7:0]};
        tleft_q <= nbits + (cfg_q.parity == smr_pkg::SMR_PAR_NONE ? 4'h1 : 4'h2);
      end
    end
    else if (tcnt_q != 17'h0)
      tcnt_q <= tcnt_q - 17'h1;
    else if (tleft_q != 4'h0)
    begin
      txd_q <= tsh_q[0];
      tsh_q <= {1'b1, tsh_q[11:1]};
      tleft_q <= tleft_q - 4'h1;
      tcnt_q <= tleft_q == 4'h1 ? stop_cycles(bt, cfg_q.stop) - 17'h1 : {1'b0, bt} - 17'h1;
    end
    else
    begin
      txd_q <= 1'b1;
      tbusy_q <= 1'b0;
    end

  // ****************************************
  // recognizer
  // ****************************************
  logic [7:0] buf_q [0:`SMR_MSG_MAX-1];
  logic [7:0] lbuf_q [0:`SMR_MSG_MAX-1];
  logic [6:0] cnt_q;
  logic [6:0] len_q;
  logic [6:0] llen_q;
  logic [31:0] hist_q;
  logic [31:0] dig_q;
  logic [31:0] last_dig_q;
  logic [31:0] live_dig_q;
  logic [31:0] ms_q;
  logic [15:0] idle_q;
  logic [15:0] actv_q;
  logic [31:0] dmask;
  logic [31:0] hist_d;
  logic [31:0] dig_d;
  logic take;
  logic hit;
  logic idle_hit;
  logic store;
  assign take = rx_stb_q && cfg_q.rec_en;
  assign dmask = 32'hFFFFFFFF >> (6'd32 - {dlen_q, 3'b000});
  assign hist_d = {hist_q[23:0], rx_byte_q};
  assign hit = take && (hist_d & dmask) == (delim_q & dmask);
  assign dig_d = (dig_q ^ {24'h0, rx_byte_q}) * `SMR_DIG_PRIME;
  assign idle_hit = cfg_q.idle_en && cfg_q.rec_en && cnt_q != 7'h0 && idle_ms_q != 16'h0
    && idle_q >= idle_ms_q;
  assign store = hit || idle_hit;

  // free-running millisecond tick for both timeouts
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ms_q <= 32'h0;
    else
      ms_q <= ms_q == 32'(`SMR_MS_CYC - 1) ? 32'h0 : ms_q + 32'h1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_q <= 7'h00;
      hist_q <= 32'h0;
      dig_q <= `SMR_DIG_INIT;
      idle_q <= 16'h0;
    end
    else if (store)
    begin
      cnt_q <= 7'h00;
      hist_q <= hit ? hist_d : 32'h0;
      dig_q <= `SMR_DIG_INIT;
      idle_q <= 16'h0;
    end
    else if (take)
    begin
      if (cnt_q != 7'(`SMR_MSG_MAX))
        cnt_q <= cnt_q + 7'h01;
      hist_q <= hist_d;
      dig_q <= dig_d;
      idle_q <= 16'h0;
    end
    else if (ms_q == 32'h0 && idle_q != 16'hFFFF)
      idle_q <= idle_q + 16'h1;

  // working buffer and the persistent copy, byte-indexed by generate
  genvar gi;
  generate
    for (gi = 0; gi < `SMR_MSG_MAX; gi = gi + 1)
    begin : g_b
      always_ff @(posedge clk)
        if (take && cnt_q == 7'(gi))
          buf_q[gi] <= rx_byte_q;
      always_ff @(posedge clk)
        if (hit && cnt_q == 7'(gi))
          lbuf_q[gi] <= rx_byte_q;
        else if (store && cnt_q > 7'(gi))
          lbuf_q[gi] <= buf_q[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      len_q <= 7'h00;
      last_dig_q <= 32'h0;
    end
    else if (store)
    begin
      len_q <= hit && cnt_q != 7'(`SMR_MSG_MAX) ? cnt_q + 7'h01 : cnt_q;
      last_dig_q <= hit ? dig_d : dig_q;
    end
    else if (cmd_clear)
    begin
      len_q <= 7'h00;
      last_dig_q <= 32'h0;
    end

  // live copy: same content, dies after the active timeout
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      llen_q <= 7'h00;
      live_dig_q <= 32'h0;
      live_valid_q <= 1'b0;
      actv_q <= 16'h0;
    end
    else if (store)
    begin
      llen_q <= hit && cnt_q != 7'(`SMR_MSG_MAX) ? cnt_q + 7'h01 : cnt_q;
      live_dig_q <= hit ? dig_d : dig_q;
      live_valid_q <= 1'b1;
      actv_q <= 16'h0;
    end
    else if (cmd_clear || (live_valid_q && actv_q >= actv_ms_q))
    begin
      llen_q <= 7'h00;
      live_dig_q <= 32'h0;
      live_valid_q <= 1'b0;
    end
    else if (ms_q == 32'h0 && live_valid_q)
      actv_q <= actv_q + 16'h1;

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rdata_q <= 32'h0;
    else if (rd)
      case (addr)
        `SMR_A_CFG: rdata_q <= {13'h0, mode_q, cfg_q};
        `SMR_A_DELIM: rdata_q <= delim_q;
        `SMR_A_DLEN: rdata_q <= {29'h0, dlen_q};
        `SMR_A_IDLE: rdata_q <= {16'h0, idle_ms_q};
        `SMR_A_ACTV: rdata_q <= {16'h0, actv_ms_q};
        `SMR_A_STAT: rdata_q <= {27'h0, rx_err_q, tbusy_q, live_valid_q, len_q != 7'h0,
                                 cnt_q != 7'h0};
        `SMR_A_LEN: rdata_q <= {25'h0, len_q};
        `SMR_A_DIG: rdata_q <= last_dig_q;
        `SMR_A_LDIG: rdata_q <= live_dig_q;
        `SMR_A_RX: rdata_q <= {24'h0, rx_byte_q};
        `SMR_A_LLEN: rdata_q <= {25'h0, llen_q};
        `SMR_A_BUF: rdata_q <= 7'(idx_q) < len_q ? {24'h0, lbuf_q[idx_q]} : 32'h0;
        `SMR_A_LBUF: rdata_q <= 7'(idx_q) < llen_q ? {24'h0, lbuf_q[idx_q]} : 32'h0;
        `SMR_A_IDX: rdata_q <= {26'h0, idx_q};
        default: rdata_q <= 32'h0;
      endcase
    else
      rdata_q <= 32'h0;
endmodule
`default_nettype wire

// file: common/smr_defs.svh
// offsets, reset values and timing counts of the serial message recognizer
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
`define SMR_CLK_HZ 50000000
`define SMR_A_CFG 4'h0
`define SMR_A_DELIM 4'h1
`define SMR_A_DLEN 4'h2
`define SMR_A_IDLE 4'h3
`define SMR_A_ACTV 4'h4
`define SMR_A_CMD 4'h5
`define SMR_A_STAT 4'h6
`define SMR_A_LEN 4'h7
`define SMR_A_DIG 4'h8
`define SMR_A_LDIG 4'h9
`define SMR_A_TX 4'hA
`define SMR_A_RX 4'hB
`define SMR_A_LLEN 4'hC
`define SMR_A_BUF 4'hD
`define SMR_A_LBUF 4'hE
`define SMR_A_IDX 4'hF
`define SMR_CFG_RST 16'h0006
`define SMR_DELIM_RST 32'h00000D0A
`define SMR_DLEN_RST 3'h2
`define SMR_IDLE_RST 16'h0000
`define SMR_ACTV_RST 16'h0064
`define SMR_MS_CYC 50000
`define SMR_MSG_MAX 64
`define SMR_DIG_INIT 32'h811C9DC5
`define SMR_DIG_PRIME 32'h01000193
`endif

// file: common/smr_pkg.sv
// types of the serial message recognizer
package smr_pkg;
  typedef enum logic [2:0] {SMR_MODE_PASS = 3'h1, SMR_MODE_CTRL = 3'h2, SMR_MODE_INJ = 3'h4}
    smr_mode_type;
  typedef enum logic [1:0] {SMR_PAR_NONE = 2'h0, SMR_PAR_ODD = 2'h1, SMR_PAR_EVEN = 2'h2}
    smr_par_type;
  typedef enum logic [1:0] {SMR_STOP_1 = 2'h0, SMR_STOP_15 = 2'h1, SMR_STOP_2 = 2'h2}
    smr_stop_type;
  typedef struct packed {
    logic [6:0] spare;
    logic idle_en;
    logic rec_en;
    logic [2:0] baud;
    smr_stop_type stop;
    smr_par_type parity;
  } smr_cfg_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } smr_bus_type;
  typedef enum logic [4:0] {SMR_S_IDLE = 5'h01, SMR_S_START = 5'h02, SMR_S_DATA = 5'h04,
    SMR_S_PAR = 5'h08, SMR_S_STOP = 5'h10} smr_state_type;
endpackage

// file: verif/smr_top_props.sv
// concurrent checks on the serial message recognizer's top-level ports
`include "smr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module smr_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata_q,
  input wire logic rxd,
  input wire logic txd_q,
  input wire logic [2:0] mode_q,
  input wire logic live_valid_q
);
  // ****************************************
  // sequences
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_cfg_wr;
    wr && addr == `SMR_A_CFG;
  endsequence
  sequence s_clear_wr;
    wr && addr == `SMR_A_CMD && wdata[0];
  endsequence
  // ****************************************
  // properties
  // ****************************************
  a_reset_vals: assert property (
    $rose(rst_n) |-> mode_q == 3'h1 && txd_q && !live_valid_q && rdata_q == 32'h0)
    else $error("port values after reset wrong");
  a_mode_onehot: assert property (
    mode_q inside {3'h1, 3'h2, 3'h4}) else $error("mode not one-hot");
  a_mode_write: assert property (
    s_cfg_wr ##0 (wdata[18:16] inside {3'h1, 3'h2, 3'h4}) |=> mode_q == $past(wdata[18:16]))
    else $error("mode write not applied");
  a_mode_zero_kept: assert property (
    s_cfg_wr ##0 (wdata[18:16] == 3'h0) |=> $stable(mode_q)) else $error("zero mode taken");
  a_mode_hold: assert property (
    !(wr && addr == `SMR_A_CFG) |=> $stable(mode_q)) else $error("mode moved without write");
  a_rdata_idle: assert property (
    !rd |=> rdata_q == 32'h0) else $error("read data outside read answer");
  a_dlen_range: assert property (
    rd && addr == `SMR_A_DLEN |=> rdata_q inside {32'h1, 32'h2, 32'h3, 32'h4})
    else $error("delimiter length out of range");
  // stores happen on a stop bit with the line high, or on an idle timeout whatever the line level
  a_live_rise_idle: assert property (
    $rose(live_valid_q) |-> rxd) else $error("live copy appeared mid frame");
  a_clear_live: assert property (
    s_clear_wr |=> !live_valid_q) else $error("clear left live copy");
endmodule
bind smr_top smr_props i_props (
  .clk(clk),
  .rst_n(rst_n),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata_q(rdata_q),
  .rxd(rxd),
  .txd_q(txd_q),
  .mode_q(mode_q),
  .live_valid_q(live_valid_q)
);
`default_nettype wire

// file: verif/smr_far_end.sv
// model of the external serial device that sends characters to the recognizer
`timescale 1ns/1ns
`default_nettype none
module smr_far_end #(
  parameter int BIT_CYC = 434
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // line idles high between characters
  initial rxd = 1'b1;
  // 8 data bits lsb first, no parity, one stop bit: matches the bench's port setup
  task automatic send_byte(input logic [7:0] b, input int gap);
    int i;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC + gap) @(posedge clk);
  endtask
  // samples the block's serial output mid-bit; returns the data and the stop level
  task automatic recv_byte(output logic [7:0] b, output logic stp);
    int i;
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    stp = txd;
  endtask
endmodule
`default_nettype wire

// file: verif/smr_tb_top.sv
// self-checking bench for the serial message recognizer
`include "smr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module smr_tb_top;
  logic clk;
  logic rst_n;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata_q;
  logic txd_q;
  logic [2:0] mode_q;
  logic live_valid_q;
  wire rxd;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] dig;
  logic [2:0] m;
  logic [7:0] rb;
  logic rstop;
  logic [7:0] msg [3] = '{8'h48, 8'h69, 8'h3A};
  logic [2:0] modes [4] = '{3'h2, 3'h4, 3'h0, 3'h1};
  smr_top i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .rxd(rxd), .txd_q(txd_q), .mode_q(mode_q), .live_valid_q(live_valid_q));
  smr_far_end #(.BIT_CYC(`SMR_CLK_HZ / 115200)) i_far (.clk(clk), .txd(txd_q), .rxd(rxd));
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata_q);
  endtask
  // bounded wait on the live-copy flag
  task automatic wait_live(input logic lvl, input int lim);
    int k;
    k = 0;
    #1;
    while (live_valid_q !== lvl && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("live_valid_q", {31'h0, lvl}, {31'h0, live_valid_q});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // clock, timeout, tests
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // one 1 ms timeout takes at most one tick; the rest is well under 40000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 140000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("mode_q", 32'h1, {29'h0, mode_q});
    chk("txd_q", 32'h1, {31'h0, txd_q});
    rd_chk(`SMR_A_CFG, 32'h00010006, "cfg");
    rd_chk(`SMR_A_DELIM, 32'h00000D0A, "delim");
    rd_chk(`SMR_A_DLEN, 32'h2, "dlen");
    rd_chk(`SMR_A_IDLE, 32'h0, "idle");
    rd_chk(`SMR_A_ACTV, 32'h64, "actv");
    // ctrl, inject, a zero that must be ignored, then pass-through; port left in pass-through at 115200
    m = 3'h1;
    foreach (modes[i])
    begin
      wr_reg(`SMR_A_CFG, {13'h0, modes[i], 16'h00F0});
      #1;
      if (modes[i] !== 3'h0)
        m = modes[i];
      chk("mode_q", {29'h0, m}, {29'h0, mode_q});
    end
    wr_reg(`SMR_A_DLEN, 32'h1);
    wr_reg(`SMR_A_DELIM, 32'h3A);
    wr_reg(`SMR_A_ACTV, 32'h1);
    rd_chk(`SMR_A_DLEN, 32'h1, "dlen");
    dig = `SMR_DIG_INIT;
    foreach (msg[i])
    begin
      i_far.send_byte(msg[i], 0);
      dig = (dig ^ {24'h0, msg[i]}) * `SMR_DIG_PRIME;
    end
    wait_live(1'b1, 2000);
    rd_chk(`SMR_A_LEN, 32'h3, "len");
    rd_chk(`SMR_A_DIG, dig, "digest");
    rd_chk(`SMR_A_LLEN, 32'h3, "live_len");
    rd_chk(`SMR_A_LDIG, dig, "live_digest");
    rd_chk(`SMR_A_STAT, 32'h6, "stat");
    rd_chk(`SMR_A_RX, 32'h3A, "rx_byte");
    foreach (msg[i])
    begin
      wr_reg(`SMR_A_IDX, i);
      rd_chk(`SMR_A_BUF, {24'h0, msg[i]}, "buf");
      rd_chk(`SMR_A_LBUF, {24'h0, msg[i]}, "live_buf");
    end
    wait_live(1'b0, 2 * `SMR_MS_CYC + 4);
    rd_chk(`SMR_A_LLEN, 32'h0, "live_len");
    rd_chk(`SMR_A_LBUF, 32'h0, "live_buf");
    rd_chk(`SMR_A_STAT, 32'h2, "stat");
    rd_chk(`SMR_A_LEN, 32'h3, "len");
    rd_chk(`SMR_A_DIG, dig, "digest");
    // a one-byte message, then a clear while the live copy still stands
    i_far.send_byte(8'h3A, 0);
    wait_live(1'b1, 2000);
    rd_chk(`SMR_A_LEN, 32'h1, "len");
    wr_reg(`SMR_A_CMD, 32'h1);
    rd_chk(`SMR_A_LEN, 32'h0, "len");
    rd_chk(`SMR_A_DIG, 32'h0, "digest");
    rd_chk(`SMR_A_LLEN, 32'h0, "live_len");
    rd_chk(`SMR_A_STAT, 32'h0, "stat");
    wr_reg(`SMR_A_CMD, 32'h2);
    rd_chk(`SMR_A_CFG, 32'h00010070, "cfg");
    rd_chk(`SMR_A_DELIM, 32'h00000D0A, "delim");
    rd_chk(`SMR_A_DLEN, 32'h2, "dlen");
    rd_chk(`SMR_A_ACTV, 32'h64, "actv");
    // recognizer now off: a full delimiter must store nothing
    i_far.send_byte(8'h0D, 0);
    i_far.send_byte(8'h0A, 100);
    rd_chk(`SMR_A_LEN, 32'h0, "len");
    chk("live_valid_q", 32'h0, {31'h0, live_valid_q});
    // one character out at 115200, 8 bits, no parity; busy still set during the stop bit
    fork
      wr_reg(`SMR_A_TX, 32'hA5);
      i_far.recv_byte(rb, rstop);
    join
    chk("tx_byte", 32'hA5, {24'h0, rb});
    chk("tx_stop", 32'h1, {31'h0, rstop});
    rd_chk(`SMR_A_STAT, 32'h8, "stat");
    tally_and_finish();
  end
endmodule
`default_nettype wire
